// *** hdl/urtx_defines.vh ***
/*
 * Register offsets, field positions, reset values and timing constants of the
 * serial transmitter and receiver core.
 * Assumes a classic Wishbone slave with 32-bit data and byte addresses.
 */
`ifndef URTX_DEFINES_VH
`define URTX_DEFINES_VH

// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define URTX_OFF_MODE     6'h00
`define URTX_OFF_STATUS   6'h04
`define URTX_OFF_COMMAND  6'h08
`define URTX_OFF_DATA     6'h0c
`define URTX_OFF_DIV_HI   6'h10
`define URTX_OFF_DIV_LO   6'h14
`define URTX_OFF_CLKSEL   6'h18

// ------------------------------------------------------------------
// Mode register fields
// ------------------------------------------------------------------
`define URTX_MODE_BITS_LSB   0
`define URTX_MODE_PAR_EN     2
`define URTX_MODE_PAR_ODD    3
`define URTX_MODE_PAR_FORCE  4
`define URTX_MODE_STOP2      5
`define URTX_MODE_ERR_BLOCK  6
`define URTX_MODE_CTS_EN     7
`define URTX_MODE_RX_RTS     8
`define URTX_MODE_TX_RTS     9
`define URTX_MODE_FULL_INT   10
`define URTX_MODE_RESET      11'h000

// ------------------------------------------------------------------
// Command register codes, written in bits 2:0; break and RTS bits 3 to 6
// ------------------------------------------------------------------
`define URTX_CMD_NONE        3'h0
`define URTX_CMD_TX_EN       3'h1
`define URTX_CMD_TX_DIS      3'h2
`define URTX_CMD_TX_RST      3'h3
`define URTX_CMD_RX_EN       3'h4
`define URTX_CMD_RX_DIS      3'h5
`define URTX_CMD_RX_RST      3'h6
`define URTX_CMD_ERR_RST     3'h7
`define URTX_CMD_BRK_BIT     3
`define URTX_CMD_BRK_STOP    4
`define URTX_CMD_RTS_SET     5
`define URTX_CMD_RTS_CLR     6

// ------------------------------------------------------------------
// Baud generation
// ------------------------------------------------------------------
`define URTX_DIV_RESET       16'h0002
`define URTX_DIV_MIN         16'h0002
`define URTX_OVERSAMPLE      5'h10
`define URTX_HALF_BIT        4'h8

`endif

// *** hdl/urtx_core.v ***
/*
 * Serial transmitter and receiver core: framing, start-bit check, break and
 * error detection, three-deep receive queue and automatic RTS control.
 * Assumes a classic Wishbone master on the system clock and asynchronous
 * serial pins; the external clock pin is sampled like any other pin.
 */
`timescale 1ns/1ps
`include "urtx_defines.vh"

module urtx_core (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        ce_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [5:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	output reg         wb_err_o,
	input  wire        rxd_i,
	input  wire        cts_n_i,
	input  wire        ext_clk_i,
	output reg         txd_o,
	output reg         rts_n_o,
	output reg         irq_o
);

	localparam TX_IDLE = 2'h0;
	localparam TX_SHIFT = 2'h1;
	localparam TX_RTS_WAIT = 2'h2;
	localparam RX_HUNT = 3'h0;
	localparam RX_START = 3'h1;
	localparam RX_DATA = 3'h2;
	localparam RX_STOP_HALF = 3'h3;
	localparam RX_RESTART = 3'h4;
	localparam RX_WAIT_HIGH = 3'h5;

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	reg [1:0] rxd_sync_q;
	reg [1:0] cts_sync_q;
	reg [1:0] ext_sync_q;
	reg       ext_prev_q;
	always @(posedge clk_i) begin
		if (rst_i) begin
			rxd_sync_q <= 2'h3;
			cts_sync_q <= 2'h3;
			ext_sync_q <= 2'h0;
			ext_prev_q <= 1'b0;
		end else if (ce_i) begin
			rxd_sync_q <= {rxd_sync_q[0], rxd_i};
			cts_sync_q <= {cts_sync_q[0], cts_n_i};
			ext_sync_q <= {ext_sync_q[0], ext_clk_i};
			ext_prev_q <= ext_sync_q[1];
		end
	end
	wire rxd = rxd_sync_q[1];
	wire cts_ok = ~cts_sync_q[1];

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	reg [10:0] mode_reg_one_q;
	reg [7:0]  divisor_high_byte_q;
	reg [7:0]  divisor_low_byte_q;
	reg        clk_ext_q;
	reg        tx_en_q;
	reg        rx_en_q;
	reg        brk_q;
	reg        rts_q;
	wire [1:0] nbits = mode_reg_one_q[`URTX_MODE_BITS_LSB+1:`URTX_MODE_BITS_LSB];
	wire       par_en = mode_reg_one_q[`URTX_MODE_PAR_EN];
	wire       par_odd = mode_reg_one_q[`URTX_MODE_PAR_ODD];
	wire       par_force = mode_reg_one_q[`URTX_MODE_PAR_FORCE];
	wire       stop2 = mode_reg_one_q[`URTX_MODE_STOP2];
	wire       blk_mode = mode_reg_one_q[`URTX_MODE_ERR_BLOCK];
	wire [3:0] dbits = {2'h0, nbits} + 4'h5;

	// Parity of the data bits, or forced to the odd/even select bit.
	function par_of;
		input [7:0] d;
		input       odd;
		input       force_;
		begin
			par_of = force_ ? odd : (^d) ^ odd;
		end
	endfunction

	// ------------------------------------------------------------------
	// Baud tick: 16x tick every divisor*2 clocks, or on each rising edge of the external clock pin; bit every 16 ticks
	// ------------------------------------------------------------------
	reg [16:0] baud_cnt_q;
	reg        tick16_q;
	wire [15:0] divisor = {divisor_high_byte_q, divisor_low_byte_q};
	wire [15:0] div_reset = `URTX_DIV_RESET;
	always @(posedge clk_i) begin
		if (rst_i) begin
			baud_cnt_q <= 17'h00000;
			tick16_q <= 1'b0;
		end else if (ce_i) begin
			if (clk_ext_q) begin
				tick16_q <= ext_sync_q[1] & ~ext_prev_q;
			end else if (baud_cnt_q >= {divisor, 1'b0} - 17'h00001) begin
				baud_cnt_q <= 17'h00000;
				tick16_q <= 1'b1;
			end else begin
				baud_cnt_q <= baud_cnt_q + 17'h00001;
				tick16_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
	wire wr_lo = wb_req & wb_we_i & wb_sel_i[0];
	wire rd_data = wb_req & ~wb_we_i & (wb_adr_i == `URTX_OFF_DATA);
	wire [2:0] cmd = (wr_lo && wb_adr_i == `URTX_OFF_COMMAND) ? wb_dat_i[2:0] : `URTX_CMD_NONE;
	wire cmd_tx_rst = cmd == `URTX_CMD_TX_RST;
	wire cmd_rx_rst = cmd == `URTX_CMD_RX_RST;
	wire load_tx = wr_lo && wb_adr_i == `URTX_OFF_DATA;

	// ------------------------------------------------------------------
	// Transmitter
	// ------------------------------------------------------------------
	reg [1:0]  tx_st_q;
	reg [7:0]  tx_hold_q;
	reg        tx_holding_free_q;
	reg        tx_all_sent_q;
	reg [11:0] tx_sh_q;
	reg [3:0]  tx_left_q;
	reg [3:0]  tx_sub_q;
	wire [7:0] tx_mask = 8'hff >> (4'h8 - dbits);
	wire [7:0] tx_d = tx_hold_q & tx_mask;
	wire [3:0] tx_len = 4'h1 + dbits + {3'h0, par_en} + (stop2 ? 4'h2 : 4'h1);
	wire       tx_go = ~tx_holding_free_q & tx_en_q & ~brk_q &
		(~mode_reg_one_q[`URTX_MODE_CTS_EN] | cts_ok);
	// The frame built LSB first: data, parity, stop ones; the start bit is driven apart.
	wire [11:0] tx_frame = ({4'h0, tx_d} | (par_en ? ({11'h000, par_of(tx_d, par_odd,
		par_force)} << dbits) : 12'h000) | (12'hfff << (dbits + {3'h0, par_en}))) ;
	reg tx_pending_dis_q;
	always @(posedge clk_i) begin
		if (rst_i || (ce_i && cmd_tx_rst)) begin
			tx_st_q <= TX_IDLE;
			tx_holding_free_q <= 1'b1;
			tx_all_sent_q <= 1'b1;
			tx_sh_q <= 12'hfff;
			tx_left_q <= 4'h0;
			tx_sub_q <= 4'h0;
			tx_hold_q <= 8'h00;
			tx_en_q <= 1'b0;
			tx_pending_dis_q <= 1'b0;
			txd_o <= 1'b1;
		end else if (ce_i) begin
			if (cmd == `URTX_CMD_TX_EN) begin
				tx_en_q <= 1'b1;
				tx_pending_dis_q <= 1'b0;
			end else if (cmd == `URTX_CMD_TX_DIS) begin
				tx_en_q <= 1'b0;
				tx_pending_dis_q <= 1'b1;
			end
			if (load_tx && tx_holding_free_q) begin
				tx_hold_q <= wb_dat_i[7:0];
				tx_holding_free_q <= 1'b0;
				tx_all_sent_q <= 1'b0;
			end
			case (tx_st_q)
			TX_IDLE: begin
				txd_o <= ~brk_q;
				if (tx_go && tick16_q) begin
					tx_sh_q <= tx_frame;
					tx_left_q <= tx_len - 4'h1;
					tx_sub_q <= 4'h0;
					txd_o <= 1'b0;
					tx_holding_free_q <= 1'b1;
					tx_st_q <= TX_SHIFT;
				end
			end
			TX_SHIFT: begin
				if (tick16_q) begin
					tx_sub_q <= tx_sub_q + 4'h1;
					if (tx_sub_q == 4'hf) begin
						if (tx_left_q == 4'h0) begin
							txd_o <= 1'b1;
							if (tx_go) begin
								tx_sh_q <= tx_frame;
								tx_left_q <= tx_len - 4'h1;
								txd_o <= 1'b0;
								tx_holding_free_q <= 1'b1;
							end else begin
								tx_all_sent_q <= tx_holding_free_q;
								tx_st_q <= TX_RTS_WAIT;
							end
						end else begin
							txd_o <= tx_sh_q[0];
							tx_sh_q <= {1'b1, tx_sh_q[11:1]};
							tx_left_q <= tx_left_q - 4'h1;
						end
					end
				end
			end
			default: begin
				if (tick16_q) begin
					tx_sub_q <= tx_sub_q + 4'h1;
					if (tx_sub_q == 4'hf) begin
						tx_st_q <= TX_IDLE;
						tx_pending_dis_q <= 1'b0;
					end
				end
			end
			endcase
		end
	end
	wire tx_rts_drop = tx_st_q == TX_RTS_WAIT && tick16_q && tx_sub_q == 4'hf &&
		tx_pending_dis_q && ~tx_en_q && mode_reg_one_q[`URTX_MODE_TX_RTS];

	// ------------------------------------------------------------------
	// Receiver
	// ------------------------------------------------------------------
	reg [2:0]  rx_st_q;
	reg [3:0]  rx_sub_q;
	reg [3:0]  rx_bit_q;
	reg [8:0]  rx_sh_q;
	reg        rx_waiting_q;
	reg [10:0] rx_wait_ent_q;
	reg        rx_break_pend_q;
	reg [10:0] q_mem_q [0:2];
	reg [1:0]  q_cnt_q;
	reg        overrun_q;
	reg [2:0]  blk_err_q;
	reg        rxd_prev_q;
	wire [3:0] rx_total = dbits + {3'h0, par_en};
	wire [7:0] rx_data = par_en ? (rx_sh_q[7:0] >> (4'h8 - dbits)) :
		(rx_sh_q[8:1] >> (4'h8 - dbits));
	wire       rx_par_bad = par_en && (rx_sh_q[8] != par_of(rx_data, par_odd, par_force));
	wire       rx_all_zero = (rx_data == 8'h00) && !(par_en && rx_sh_q[8]);
	wire       q_full = q_cnt_q == 2'h3;
	wire       pop = rd_data && q_cnt_q != 2'h0;
	wire       push = rx_waiting_q && (!q_full || pop);
	wire [1:0] q_after_pop = pop ? q_cnt_q - 2'h1 : q_cnt_q;
	wire [7:0] rx_data_ext = rx_data;
	wire [7:0] rx_char = rx_data_ext;
	wire       start_ok = rx_st_q == RX_START && tick16_q && rx_sub_q == 4'h7 && !rxd;
	reg [8:0]  rx_shift_nx;
	always @* begin
		rx_shift_nx = {rxd, rx_sh_q[8:1]};
	end
	integer i;
	always @(posedge clk_i) begin
		if (rst_i || (ce_i && cmd_rx_rst)) begin
			rx_st_q <= RX_HUNT;
			rx_sub_q <= 4'h0;
			rx_bit_q <= 4'h0;
			rx_sh_q <= 9'h000;
			rx_waiting_q <= 1'b0;
			rx_wait_ent_q <= 11'h000;
			rx_break_pend_q <= 1'b0;
			q_cnt_q <= 2'h0;
			overrun_q <= 1'b0;
			blk_err_q <= 3'h0;
			rx_en_q <= 1'b0;
			rxd_prev_q <= 1'b1;
			for (i = 0; i < 3; i = i + 1) begin
				q_mem_q[i] <= 11'h000;
			end
		end else if (ce_i) begin
			rxd_prev_q <= rxd;
			if (cmd == `URTX_CMD_RX_EN) begin
				rx_en_q <= 1'b1;
			end else if (cmd == `URTX_CMD_RX_DIS) begin
				rx_en_q <= 1'b0;
			end
			if (cmd == `URTX_CMD_ERR_RST) begin
				blk_err_q <= 3'h0;
				overrun_q <= 1'b0;
			end
			// Queue shift: pop moves entries toward the head.
			if (pop) begin
				q_mem_q[0] <= q_mem_q[1];
				q_mem_q[1] <= q_mem_q[2];
				if (blk_mode && q_cnt_q > 2'h1) begin
					blk_err_q <= blk_err_q | q_mem_q[1][10:8];
				end
			end
			if (push) begin
				q_mem_q[q_after_pop] <= rx_wait_ent_q;
				rx_waiting_q <= 1'b0;
				if (blk_mode && q_after_pop == 2'h0) begin
					blk_err_q <= blk_err_q | rx_wait_ent_q[10:8];
				end
			end
			q_cnt_q <= q_after_pop + {1'b0, push};
			case (rx_st_q)
			RX_HUNT: begin
				if (rx_en_q && rxd_prev_q && !rxd) begin
					rx_st_q <= RX_START;
					rx_sub_q <= 4'h0;
				end
			end
			RX_START: begin
				if (tick16_q) begin
					rx_sub_q <= rx_sub_q + 4'h1;
					if (rxd) begin
						rx_st_q <= RX_HUNT;
					end else if (rx_sub_q == 4'h7) begin
						rx_st_q <= RX_DATA;
						rx_sub_q <= 4'h0;
						rx_bit_q <= 4'h0;
						if (rx_waiting_q && q_full && !pop) begin
							rx_waiting_q <= 1'b0;
							overrun_q <= 1'b1;
						end
					end
				end
			end
			RX_DATA: begin
				if (tick16_q) begin
					rx_sub_q <= rx_sub_q + 4'h1;
					if (rx_sub_q == 4'hf) begin
						rx_bit_q <= rx_bit_q + 4'h1;
						if (rx_bit_q == rx_total) begin
							// Stop sample at mid-point.
							rx_waiting_q <= 1'b1;
							rx_wait_ent_q <= {rx_all_zero && !rxd, !rxd, rx_par_bad,
								rx_all_zero && !rxd ? 8'h00 : rx_char};
							rx_sub_q <= 4'h0;
							if (!rxd && rx_all_zero) begin
								rx_st_q <= RX_WAIT_HIGH;
							end else if (!rxd) begin
								rx_break_pend_q <= 1'b1;
								rx_st_q <= RX_RESTART;
							end else begin
								rx_st_q <= RX_HUNT;
							end
						end else begin
							rx_sh_q <= rx_shift_nx;
						end
					end
				end
			end
			RX_RESTART: begin
				if (tick16_q) begin
					rx_sub_q <= rx_sub_q + 4'h1;
					if (rxd) begin
						rx_st_q <= RX_HUNT;
						rx_break_pend_q <= 1'b0;
					end else if (rx_sub_q == 4'h7) begin
						rx_st_q <= RX_DATA;
						rx_sub_q <= 4'h0;
						rx_bit_q <= 4'h0;
						rx_sh_q <= 9'h000;
					end
				end
			end
			RX_WAIT_HIGH: begin
				if (tick16_q) begin
					rx_sub_q <= rxd ? rx_sub_q + 4'h1 : 4'h0;
					if (rxd && rx_sub_q == `URTX_HALF_BIT - 4'h1) begin
						rx_st_q <= RX_HUNT;
						rx_break_pend_q <= 1'b0;
					end
				end
			end
			default: begin
				rx_st_q <= RX_HUNT;
			end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Status, RTS and register access
	// ------------------------------------------------------------------
	wire [2:0] head_err = q_cnt_q != 2'h0 ? q_mem_q[0][10:8] : 3'h0;
	wire [2:0] show_err = blk_mode ? blk_err_q : head_err;
	wire [7:0] status_reg = {show_err[2], show_err[1], show_err[0], overrun_q,
		tx_all_sent_q, tx_holding_free_q, q_full, q_cnt_q != 2'h0};
	always @(posedge clk_i) begin
		if (rst_i) begin
			mode_reg_one_q <= `URTX_MODE_RESET;
			divisor_high_byte_q <= div_reset[15:8];
			divisor_low_byte_q <= div_reset[7:0];
			clk_ext_q <= 1'b0;
			brk_q <= 1'b0;
			rts_q <= 1'b0;
			rts_n_o <= 1'b1;
			irq_o <= 1'b0;
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else if (ce_i) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
			if (cmd_rx_rst) begin
				rts_q <= rts_q & ~mode_reg_one_q[`URTX_MODE_RX_RTS];
			end
			if (wr_lo && wb_adr_i == `URTX_OFF_COMMAND) begin
				if (wb_dat_i[`URTX_CMD_BRK_BIT]) begin
					brk_q <= 1'b1;
				end else if (wb_dat_i[`URTX_CMD_BRK_STOP]) begin
					brk_q <= 1'b0;
				end
				if (wb_dat_i[`URTX_CMD_RTS_SET]) begin
					rts_q <= 1'b1;
				end else if (wb_dat_i[`URTX_CMD_RTS_CLR]) begin
					rts_q <= 1'b0;
				end
			end
			if (tx_rts_drop) begin
				rts_q <= 1'b0;
			end
			if (mode_reg_one_q[`URTX_MODE_RX_RTS]) begin
				if (start_ok && q_full) begin
					rts_q <= 1'b0;
				end else if (!q_full) begin
					rts_q <= 1'b1;
				end
			end
			rts_n_o <= ~rts_q;
			irq_o <= mode_reg_one_q[`URTX_MODE_FULL_INT] ? q_full : q_cnt_q != 2'h0;
			if (wb_req) begin
				if (wb_adr_i == `URTX_OFF_MODE) begin
					wb_ack_o <= 1'b1;
					wb_dat_o <= {21'h000000, mode_reg_one_q};
					if (wb_we_i && wb_sel_i[0]) begin
						mode_reg_one_q[7:0] <= wb_dat_i[7:0];
					end
					if (wb_we_i && wb_sel_i[1]) begin
						mode_reg_one_q[10:8] <= wb_dat_i[10:8];
					end
				end else if (wb_adr_i == `URTX_OFF_STATUS) begin
					wb_ack_o <= 1'b1;
					wb_dat_o <= {24'h000000, status_reg};
				end else if (wb_adr_i == `URTX_OFF_COMMAND) begin
					wb_ack_o <= 1'b1;
				end else if (wb_adr_i == `URTX_OFF_DATA) begin
					wb_ack_o <= 1'b1;
					wb_dat_o <= {21'h000000, q_mem_q[0] & {11{q_cnt_q != 2'h0}}};
				end else if (wb_adr_i == `URTX_OFF_DIV_HI) begin
					wb_ack_o <= 1'b1;
					wb_dat_o <= {24'h000000, divisor_high_byte_q};
					if (wr_lo) begin
						divisor_high_byte_q <= wb_dat_i[7:0];
					end
				end else if (wb_adr_i == `URTX_OFF_DIV_LO) begin
					wb_ack_o <= 1'b1;
					wb_dat_o <= {24'h000000, divisor_low_byte_q};
					if (wr_lo) begin
						divisor_low_byte_q <= wb_dat_i[7:0];
					end
				end else if (wb_adr_i == `URTX_OFF_CLKSEL) begin
					wb_ack_o <= 1'b1;
					wb_dat_o <= {31'h00000000, clk_ext_q};
					if (wr_lo) begin
						clk_ext_q <= wb_dat_i[0];
					end
				end else begin
					wb_err_o <= 1'b1;
				end
			end
		end
	end

endmodule // urtx_core

// *** tb/urtx_chk.sv ***
/*
 * Port checker for the serial core, bound to every urtx_core instance.
 * Assumes the bus contract of the core and one system clock.
 */
`timescale 1ns/1ps
module urtx_chk (
	input wire        clk_i,
	input wire        rst_i,
	input wire        ce_i,
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire        wb_we_i,
	input wire [5:0]  wb_adr_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire        wb_ack_o,
	input wire        wb_err_o,
	input wire        txd_o,
	input wire        rts_n_o,
	input wire        irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	reg  loaded_q;
	wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && ce_i;
	wire wr_done = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i;
	// ----------
	// Marks the first load or break request since reset.
	// ----------
	always @(posedge clk_i) begin
		if (rst_i)
			loaded_q <= 1'b0;
		else if (wr_done && (wb_adr_i == 6'h0c || (wb_adr_i == 6'h08 && wb_dat_i[3])))
			loaded_q <= 1'b1;
	end
	sequence s_take;
		req;
	endsequence
	sequence s_rd(a);
		s_take ##0 (!wb_we_i && wb_adr_i == a);
	endsequence
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	a_take_answer: assert property (s_take |=> wb_ack_o != wb_err_o)
		else $error("request not answered in one cycle");
	a_no_stray: assert property (!req |=> !wb_ack_o && !wb_err_o)
		else $error("answer without request");
	a_unmapped_err: assert property (s_take ##0 (wb_adr_i > 6'h18) |=> wb_err_o)
		else $error("unmapped address not refused");
	a_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	a_cmd_reads: assert property (s_rd(6'h08) |=> wb_dat_o == 32'h0)
		else $error("command register not reading zero");
	a_status_width: assert property (s_rd(6'h04) |=> wb_dat_o[31:8] == 24'h0)
		else $error("status upper bits set");
	a_reset_idle: assert property ($fell(rst_i) |-> txd_o && rts_n_o && !irq_o && !wb_ack_o)
		else $error("outputs not idle after reset");
	a_line_idle: assert property (!loaded_q |-> txd_o)
		else $error("line low with nothing loaded");
	a_rts_cmd: assert property (s_take ##0 (wb_we_i && wb_adr_i == 6'h08 &&
		wb_dat_i[6:5] == 2'b01) |=> ##[0:2] !rts_n_o)
		else $error("request-to-send not asserted");
endmodule // urtx_chk

bind urtx_core urtx_chk chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .txd_o(txd_o),
	.rts_n_o(rts_n_o), .irq_o(irq_o));

// *** tb/urtx_peer.sv ***
/*
 * Remote serial port: sends 8-bit frames and receives 8N1 frames.
 * Assumes the core's default divisor, so one bit lasts BIT clocks.
 */
`timescale 1ns/1ps
module urtx_peer #(
	parameter int BIT = 64
) (
	input  wire  clk_i,
	input  wire  txd_i,
	output logic rxd_o,
	output logic cts_n_o
);
	logic [7:0] rx_byte;
	logic       rx_stop;
	int         rx_cnt;
	initial begin
		rxd_o = 1'b1;
		cts_n_o = 1'b0;
		rx_cnt = 0;
	end
	// A bad stop bit is cut short so the line is high again before a restart.
	task automatic send(input [7:0] d, input stp);
		logic [9:0] f;
		f = {stp, d, 1'b0};
		@(posedge clk_i);
		for (int i = 0; i < 10; i++) begin
			rxd_o <= f[i];
			repeat ((i == 9 && !stp) ? BIT * 3 / 4 : BIT) @(posedge clk_i);
		end
		rxd_o <= 1'b1;
		repeat (BIT) @(posedge clk_i);
	endtask
	always begin
		@(negedge txd_i);
		repeat (BIT / 2) @(posedge clk_i);
		if (!txd_i) begin
			for (int i = 0; i < 8; i++) begin
				repeat (BIT) @(posedge clk_i);
				rx_byte[i] = txd_i;
			end
			repeat (BIT) @(posedge clk_i);
			rx_stop = txd_i;
			rx_cnt++;
		end
	end
endmodule // urtx_peer

// *** tb/tb_top.sv ***
/*
 * Self-checking bench for the serial core with a remote serial port.
 * Assumes reset divisor, 40 MHz clock and the core's register map.
 */
`timescale 1ns/1ps
module tb_top;
	reg         clk_i = 1'b0;
	reg         rst_i;
	reg         ce_i;
	reg         wb_cyc_i;
	reg         wb_stb_i;
	reg         wb_we_i;
	reg  [5:0]  wb_adr_i;
	reg  [3:0]  wb_sel_i;
	reg  [31:0] wb_dat_i;
	reg         ext_clk_i;
	wire [31:0] wb_dat_o;
	wire        wb_ack_o;
	wire        wb_err_o;
	wire        rxd_i;
	wire        cts_n_i;
	wire        txd_o;
	wire        rts_n_o;
	wire        irq_o;
	int         n_mismatch = 0;
	int         checks = 0;
	always #12.5 clk_i = ~clk_i;
	urtx_core uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
		.rxd_i(rxd_i), .cts_n_i(cts_n_i), .ext_clk_i(ext_clk_i), .txd_o(txd_o),
		.rts_n_o(rts_n_o), .irq_o(irq_o));
	urtx_peer peer (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd_i), .cts_n_o(cts_n_i));
	// ----------
	// Shared tasks.
	// ----------
	task chk(input [31:0] got, input [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input [5:0] a, input w, input [31:0] d, output [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 50);
		if (n >= 50)
			n_mismatch++;
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic wr(input [5:0] a, input [31:0] d);
		logic [31:0] q;
		bus(a, 1'b1, d, q);
	endtask
	task automatic rd_chk(input [5:0] a, input [31:0] m, input [31:0] e);
		logic [31:0] q;
		bus(a, 1'b0, 32'h0, q);
		chk(q & m, e);
	endtask
	task automatic wait_rx(input int n0);
		int n;
		n = 0;
		while (peer.rx_cnt <= n0 && n < 3000) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 3000)
			n_mismatch++;
	endtask
	task automatic wait_free;
		logic [31:0] q;
		int n;
		q = 32'h0;
		n = 0;
		while (q[2] !== 1'b1 && n < 200) begin
			bus(6'h04, 1'b0, 32'h0, q);
			n++;
		end
		if (n >= 200)
			n_mismatch++;
	endtask
	// ----------
	// Scenarios.
	// ----------
	task t_reset;
		rd_chk(6'h00, 32'hffffffff, 32'h0);
		rd_chk(6'h04, 32'h5, 32'h4);
		rd_chk(6'h10, 32'hffffffff, 32'h0);
		rd_chk(6'h14, 32'hffffffff, 32'h2);
		wr(6'h14, 32'h2);
		rd_chk(6'h1c, 32'hffffffff, 32'h0);
		wr(6'h08, 32'h20);
		repeat (2) @(posedge clk_i);
		chk(rts_n_o, 1'b0);
		wr(6'h08, 32'h40);
		repeat (2) @(posedge clk_i);
		chk(rts_n_o, 1'b1);
		$display("reset test done");
	endtask
	task automatic t_tx;
		int n0;
		wr(6'h00, 32'h3);
		wr(6'h08, 32'h1);
		n0 = peer.rx_cnt;
		wr(6'h0c, 32'ha5);
		wait_free;
		wr(6'h0c, 32'h3c);
		rd_chk(6'h04, 32'h4, 32'h0);
		wait_rx(n0);
		chk(peer.rx_byte, 8'ha5);
		chk(peer.rx_stop, 1'b1);
		wait_rx(n0 + 1);
		chk(peer.rx_byte, 8'h3c);
		repeat (80) @(posedge clk_i);
		rd_chk(6'h04, 32'hc, 32'hc);
		wr(6'h0c, 32'h81);
		wait_free;
		wr(6'h08, 32'h2);
		wait_rx(n0 + 2);
		chk(peer.rx_byte, 8'h81);
		$display("transmit test done");
	endtask
	task automatic t_cts;
		int n0;
		wr(6'h00, 32'h83);
		peer.cts_n_o <= 1'b1;
		wr(6'h08, 32'h1);
		n0 = peer.rx_cnt;
		wr(6'h0c, 32'h66);
		repeat (1500) @(posedge clk_i);
		chk(peer.rx_cnt, n0);
		peer.cts_n_o <= 1'b0;
		wait_rx(n0);
		chk(peer.rx_byte, 8'h66);
		wr(6'h0c, 32'h99);
		wait (txd_o === 1'b0);
		peer.cts_n_o <= 1'b1;
		wait_rx(n0 + 1);
		chk(peer.rx_byte, 8'h99);
		peer.cts_n_o <= 1'b0;
		$display("flow control test done");
	endtask
	task automatic t_txrst;
		wr(6'h0c, 32'h0);
		wait (txd_o === 1'b0);
		repeat (200) @(posedge clk_i);
		wr(6'h08, 32'h3);
		rd_chk(6'h04, 32'hc, 32'hc);
		chk(txd_o, 1'b1);
		repeat (300) @(posedge clk_i);
		chk(txd_o, 1'b1);
		$display("transmitter reset test done");
	endtask
	task automatic t_rxq;
		wr(6'h00, 32'h103);
		wr(6'h08, 32'h4);
		for (int i = 0; i < 3; i++)
			peer.send(8'h10 + i, 1'b1);
		rd_chk(6'h04, 32'h3, 32'h3);
		rd_chk(6'h04, 32'h3, 32'h3);
		peer.send(8'h20, 1'b1);
		peer.send(8'h21, 1'b1);
		rd_chk(6'h04, 32'h13, 32'h13);
		chk(rts_n_o, 1'b1);
		for (int i = 0; i < 3; i++)
			rd_chk(6'h0c, 32'h7ff, 32'h10 + i);
		chk(rts_n_o, 1'b0);
		rd_chk(6'h0c, 32'h7ff, 32'h21);
		rd_chk(6'h04, 32'h1, 32'h0);
		wr(6'h08, 32'h7);
		rd_chk(6'h04, 32'h10, 32'h0);
		$display("queue test done");
	endtask
	task t_rxerr;
		wr(6'h00, 32'h43);
		peer.send(8'h5a, 1'b0);
		rd_chk(6'h04, 32'h41, 32'h41);
		rd_chk(6'h0c, 32'h7ff, 32'h25a);
		peer.send(8'h00, 1'b0);
		rd_chk(6'h0c, 32'h4ff, 32'h400);
		rd_chk(6'h04, 32'he0, 32'hc0);
		wr(6'h08, 32'h7);
		rd_chk(6'h04, 32'he0, 32'h0);
		wr(6'h00, 32'h2);
		peer.send(8'hff, 1'b1);
		rd_chk(6'h0c, 32'hff, 32'h7f);
		$display("error test done");
	endtask
	task t_rxrst;
		peer.send(8'h44, 1'b1);
		chk(irq_o, 1'b1);
		wr(6'h08, 32'h6);
		rd_chk(6'h04, 32'h3, 32'h0);
		chk(irq_o, 1'b0);
		$display("receiver reset test done");
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		rst_i = 1'b1;
		ce_i = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 6'h0;
		wb_sel_i = 4'hf;
		wb_dat_i = 32'h0;
		ext_clk_i = 1'b0;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset;
		t_tx;
		t_cts;
		t_txrst;
		t_rxq;
		t_rxerr;
		t_rxrst;
		wrap_up;
	end
	initial begin
		repeat (40000) @(posedge clk_i);
		n_mismatch++;
		wrap_up;
	end
endmodule // tb_top
